// [core/dpce_pkg.sv]
`default_nettype none

package dpce_pkg;

  // ==========================================================
  // erase sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RAM_REQ,
    ST_RAM_WAIT,
    ST_FLASH_REQ,
    ST_FLASH_WAIT
  } dpce_state_e;

  // ==========================================================
  // request bundle toward the memory and flash controllers
  typedef struct packed {
    logic ramClear;      // wipe all volatile memories
    logic flashErase;    // erase main array incl. eeprom emulation, not aux rows
    logic clearSecurity; // drop the security bit
  } dpce_mem_req_s;

  localparam logic       PROBE_RESET_VAL = 1'b0;
  localparam logic       DONE_RESET_VAL  = 1'b0;
  localparam logic       HOLD_RESET_VAL  = 1'b0;
  localparam logic       HIST_RESET_VAL  = 1'h0;
  localparam logic       BUSY_RESET_VAL  = 1'h0;
  localparam logic [2:0] MEM_REQ_IDLE    = 3'h0;

endpackage : dpce_pkg

`default_nettype wire

// [core/dpce_probe_erase.sv]
`timescale 1ns/100ps
`default_nettype none

module dpce_probe_erase (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   porActive,
  input  wire logic                   extResetActive,
  input  wire logic                   swclkLow,
  input  wire logic                   securityBit,
  input  wire logic                   guardProtect,
  input  wire logic                   eraseCmdWrite,
  input  wire logic                   eraseCmdBit,
  input  wire logic                   cpuHoldRelease,
  input  wire logic                   ramClearDone,
  input  wire logic                   flashEraseDone,
  output logic                        probe_attached_flag,
  output logic                        erase_done_flag,
  output logic                        eraseBusy,
  output logic                        cpuResetHold,
  output dpce_pkg::dpce_mem_req_s     memReq
);
  import dpce_pkg::*;

  // ==========================================================
  // probe detection
  logic        extResetDly_r;
  logic        swclkDly_r;
  logic        probe_r;
  logic        probe_nxt;
  logic        hold_r;
  logic        hold_nxt;

  // ==========================================================
  // detection decode
  // pads live after por
  wire padsLive    = ~porActive;
  // external reset released at this edge
  wire extReleased = extResetDly_r & ~extResetActive;
  // swclk driven low at this edge
  wire swclkFell   = swclkDly_r & swclkLow;

  // cold plug: swclk held low while external reset releases after por
  wire coldPlug = extReleased & swclkLow & padsLive;
  // hot plug: falling swclk edge outside reset
  wire hotPlug  = swclkFell & ~extResetActive & padsLive;
  wire hotOk    = hotPlug & ~securityBit;

  assign probe_nxt = probe_r | coldPlug | hotOk;
  // a cold plug wins over a release in the same cycle
  // hold cpu on cold plug
  assign hold_nxt  = coldPlug | (hold_r & ~cpuHoldRelease);

  // ==========================================================
  // detection registers
  // pin history; a cleared history cannot look like an edge after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extResetDly_r <= HIST_RESET_VAL;
      swclkDly_r    <= HIST_RESET_VAL;
    end else begin
      extResetDly_r <= extResetActive;
      swclkDly_r    <= ~swclkLow;
    end
  end

  // sticky probe attached flag, cleared only by reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      probe_r <= PROBE_RESET_VAL;
    end else begin
      probe_r <= probe_nxt;
    end
  end

  // cpu reset hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_r <= HOLD_RESET_VAL;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // ==========================================================
  // chip erase sequencer
  dpce_state_e   state_r;
  dpce_state_e   state_nxt;
  logic          done_r;
  logic          done_nxt;
  dpce_mem_req_s req_r;
  dpce_mem_req_s req_nxt;

  // ==========================================================
  // erase command decode
  // start on one written
  wire eraseStart = eraseCmdWrite & eraseCmdBit & ~guardProtect;

  // ==========================================================
  // next state and request decode
  always_comb begin
    // hold state and flag, no request unless a state asks
    state_nxt = state_r;
    done_nxt  = done_r;
    req_nxt   = MEM_REQ_IDLE;
    case (state_r)
      ST_IDLE: begin
        if (eraseStart) begin
          done_nxt  = 1'b0;
          state_nxt = ST_RAM_REQ;
        end
      end
      ST_RAM_REQ: begin
        req_nxt.ramClear = 1'b1;
        state_nxt        = ST_RAM_WAIT;
      end
      ST_RAM_WAIT: begin
        req_nxt.ramClear = ~ramClearDone;
        if (ramClearDone) begin
          state_nxt = ST_FLASH_REQ;
        end
      end
      ST_FLASH_REQ: begin
        req_nxt.flashErase    = 1'b1;
        req_nxt.clearSecurity = 1'b1;
        state_nxt             = ST_FLASH_WAIT;
      end
      ST_FLASH_WAIT: begin
        req_nxt.flashErase    = ~flashEraseDone;
        req_nxt.clearSecurity = ~flashEraseDone;
        if (flashEraseDone) begin
          done_nxt  = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // sequencer registers
  // erase sequencer state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // erase done flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_r <= DONE_RESET_VAL;
    end else begin
      done_r <= done_nxt;
    end
  end

  // request bundle toward the controllers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_r <= MEM_REQ_IDLE;
    end else begin
      req_r <= req_nxt;
    end
  end

  // ==========================================================
  // busy flag
  // decoded from the state being entered, so busy rises with the start edge
  wire  busy_nxt = (state_nxt != ST_IDLE);
  logic busy_r;

  // busy flag register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= BUSY_RESET_VAL;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign probe_attached_flag = probe_r;
  assign erase_done_flag     = done_r;
  assign eraseBusy           = busy_r;
  assign cpuResetHold        = hold_r;
  assign memReq              = req_r;

endmodule : dpce_probe_erase

`default_nettype wire

// [tb/dpce_chk.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========
// port checker
module dpce_chk import dpce_pkg::*; (
  input wire logic    clk, rst, porActive, extResetActive, swclkLow, securityBit,
  input wire logic    guardProtect, eraseCmdWrite, eraseCmdBit, ramClearDone, flashEraseDone,
  input wire logic    probe_attached_flag, erase_done_flag, eraseBusy, cpuResetHold,
  input wire dpce_mem_req_s memReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // erase start: busy, done low, then wipe volatile memory alone
  sequence s_go;
    eraseBusy && !erase_done_flag ##1 memReq.ramClear && !memReq.flashErase;
  endsequence
  cold_plug_a: assert property (
    $fell(extResetActive) && swclkLow && !porActive |=> probe_attached_flag && cpuResetHold)
    else $error("cold plug missed");
  hot_plug_a: assert property (
    $rose(swclkLow) && !extResetActive && !porActive && !securityBit |=> probe_attached_flag)
    else $error("hot plug missed");
  por_block_a: assert property (
    porActive && !probe_attached_flag |=> !probe_attached_flag) else $error("detect in por");
  hot_secure_a: assert property (
    securityBit && !probe_attached_flag && !$fell(extResetActive) |=> !probe_attached_flag)
    else $error("hot plug while protected");
  guard_drop_a: assert property (
    eraseCmdWrite && eraseCmdBit && guardProtect && !eraseBusy |=> !eraseBusy)
    else $error("guarded erase ran");
  erase_start_a: assert property (
    eraseCmdWrite && eraseCmdBit && !guardProtect && !eraseBusy |=> s_go)
    else $error("erase start wrong");
  flash_order_a: assert property (
    $rose(memReq.flashErase) |-> memReq.clearSecurity && $past(ramClearDone, 2))
    else $error("flash before ram");
  done_set_a: assert property (
    memReq.flashErase && flashEraseDone |=> erase_done_flag && !eraseBusy
      && memReq == MEM_REQ_IDLE) else $error("done missing");
  busy_done_a: assert property (
    eraseBusy |-> !erase_done_flag) else $error("done while busy");
endmodule : dpce_chk
bind dpce_probe_erase dpce_chk u_dpce_chk (.*);
`default_nettype wire

// [tb/dpce_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========
// memory and flash controller answering after dly cycles
module dpce_mem_model import dpce_pkg::*; (
  input wire logic    clk,
  input wire dpce_mem_req_s memReq,
  input var int       dly,
  output logic        ramClearDone,
  output logic        flashEraseDone
);
  int n = 0;
  initial {ramClearDone, flashEraseDone} = 2'h0;
  // one done pulse per request
  always @(posedge clk) begin
    n <= (memReq.ramClear || memReq.flashErase) ? n + 1 : 0;
    ramClearDone <= memReq.ramClear && n == dly;
    flashEraseDone <= memReq.flashErase && n == dly;
  end
endmodule : dpce_mem_model
`default_nettype wire

// [tb/dpce_probe_erase_tb.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========
// bench top
module dpce_probe_erase_tb;
  import dpce_pkg::*;
  logic clk, rst, porActive, extResetActive, swclkLow, securityBit, guardProtect;
  logic eraseCmdWrite, eraseCmdBit, cpuHoldRelease, ramClearDone, flashEraseDone;
  logic probe_attached_flag, erase_done_flag, eraseBusy, cpuResetHold;
  logic doneExp = 1'h0;
  dpce_mem_req_s memReq;
  int dly = 2, miscompares = 0, cmp_count = 0, cyc = 0;
  dpce_probe_erase u_dpce_probe_erase (.*);
  dpce_mem_model u_dpce_mem_model (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(logic g, logic e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic wrap_up;
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  // erase command with guard and bit value, then poll until busy drops
  task automatic erase(int d, logic g, logic b);
    logic go;
    logic sawFlash;
    go = b & ~g;
    sawFlash = 1'h0;
    dly <= d;
    guardProtect <= g;
    eraseCmdWrite <= 1'h1;
    eraseCmdBit <= b;
    tick(1);
    eraseCmdWrite <= 1'h0;
    @(negedge clk);
    chk(eraseBusy, go);
    chk(erase_done_flag, doneExp & ~go);
    @(negedge clk);
    chk(memReq.ramClear, go);
    chk(memReq.flashErase, 1'h0);
    for (int i = 0; i < 60 && eraseBusy; i++) begin
      @(negedge clk);
      sawFlash = sawFlash | (memReq.flashErase & memReq.clearSecurity);
    end
    if (go) doneExp = 1'h1;
    chk(eraseBusy, 1'h0);
    chk(erase_done_flag, doneExp);
    chk(sawFlash, go);
    chk(memReq.clearSecurity, 1'h0);
    tick(1);
  endtask : erase
  initial begin
    {rst, porActive, extResetActive, swclkLow, securityBit} = 5'h10;
    {guardProtect, eraseCmdWrite, eraseCmdBit, cpuHoldRelease} = 4'h0;
    tick(8);
    rst <= 1'h0;
    porActive <= 1'h1;
    extResetActive <= 1'h1;
    swclkLow <= 1'h1;
    tick(2);
    extResetActive <= 1'h0;
    tick(2);
    @(negedge clk) chk(probe_attached_flag, 1'h0);
    tick(1);
    porActive <= 1'h0;
    securityBit <= 1'h1;
    swclkLow <= 1'h0;
    tick(2);
    swclkLow <= 1'h1;
    tick(2);
    @(negedge clk) chk(probe_attached_flag, 1'h0);
    tick(1);
    extResetActive <= 1'h1;
    tick(3);
    extResetActive <= 1'h0;
    tick(2);
    @(negedge clk) chk(probe_attached_flag, 1'h1);
    chk(cpuResetHold, 1'h1);
    tick(1);
    cpuHoldRelease <= 1'h1;
    tick(1);
    cpuHoldRelease <= 1'h0;
    @(negedge clk) chk(cpuResetHold, 1'h0);
    tick(1);
    erase(1, 1'h1, 1'h1);
    erase(1, 1'h0, 1'h0);
    erase(1, 1'h0, 1'h1);
    erase(6, 1'h0, 1'h1);
    rst <= 1'h1;
    tick(2);
    @(negedge clk) chk(probe_attached_flag, 1'h0);
    chk(erase_done_flag, 1'h0);
    tick(1);
    rst <= 1'h0;
    securityBit <= 1'h0;
    swclkLow <= 1'h0;
    tick(2);
    swclkLow <= 1'h1;
    tick(2);
    @(negedge clk) chk(probe_attached_flag, 1'h1);
    wrap_up();
  end
endmodule : dpce_probe_erase_tb
`default_nettype wire
